// [rtl/half_bridge_interlock_desat.sv]
// half-bridge interlock, dead-time insertion, desaturation trip and halt logic
`timescale 1ns/1ps
`default_nettype none
module half_bridge_interlock_desat
    import interlock_pkg::*;
#(
    parameter int unsigned HALT_CYCLES = interlock_pkg::HALT_CYC
) (
    input  wire logic                     CLK,
    input  wire logic                     SYS_RST,
    input  wire interlock_pkg::side_t     CMD,
    input  wire interlock_pkg::straps_t   STRAPS,
    input  wire interlock_pkg::side_t     DESAT,
    input  wire logic                     FAIL_IN,
    output interlock_pkg::side_t          GATE,
    output logic                          HALT_OUT,
    output logic                          FAULT_OUT,
    output logic                          IRQ,
    input  wire logic [3:0]               REG_ADDR,
    input  wire logic [31:0]              REG_WDATA,
    input  wire logic                     REG_WR,
    input  wire logic                     REG_RD,
    output logic [31:0]                   REG_RDATA
);
    import interlock_pkg::*;

    // dead-time cycles from the three strap levels
    function automatic logic [GAP_W-1:0] dead_time_cycles(input straps_t s);
        logic [GAP_W-1:0] units;
        units = GAP_W'({s.dead_time_strap_a_n, s.dead_time_strap_b_n}) + GAP_W'(1);
        dead_time_cycles = GAP_W'(units * GAP_W'(DEAD_UNIT_CYC))
                         + (s.dead_time_fine_strap_n ? GAP_W'(0) : GAP_W'(DEAD_FINE_CYC));
    endfunction

    // saturating counter step
    function automatic logic [GAP_W-1:0] sat_inc(input logic [GAP_W-1:0] v);
        sat_inc = (&v) ? v : v + GAP_W'(1);
    endfunction

    mode_t            state_q, state_d;
    side_t            gate_q, gate_d;
    side_t            trip;
    logic [GAP_W-1:0] dead_cyc_q, dead_cyc_d;
    logic             bypass_q, bypass_d;
    logic [GAP_W-1:0] gap_h_q, gap_h_d, gap_l_q, gap_l_d;
    logic [GAP_W-1:0] blank_h_q, blank_h_d, blank_l_q, blank_l_d;
    logic [31:0]      timer_q, timer_d;
    logic [LOW_W-1:0] low_q, low_d;
    logic             halt_q, halt_d, fault_q, fault_d;
    logic             sw_fail, fail_evt, resume_ok, resumed;
    logic [ST_W-1:0]  status_q, status_d, mask_q, mask_d;
    logic             irq_q, irq_d;
    logic [31:0]      rdata_q, rdata_d;

    // desat trip only while on and after blanking
    always_comb begin
        trip.high = gate_q.high && (blank_h_q >= GAP_W'(BLANK_CYC)) && DESAT.high;
        trip.low  = gate_q.low && (blank_l_q >= GAP_W'(BLANK_CYC)) && DESAT.low;
        sw_fail   = REG_WR && (REG_ADDR == OFS_CTRL) && REG_WDATA[CTRL_FAIL];
        fail_evt  = trip.high || trip.low || FAIL_IN || sw_fail;  // overlap is no failure
        resume_ok = (timer_q >= 32'(HALT_CYCLES)) && !FAIL_IN
                 && (low_q > LOW_W'(LOW_CYC));
    end

    // gate forwarding with interlock and dead time
    always_comb begin
        gate_d = '0;
        if (state_q == ST_RUN && !fail_evt) begin
            if (bypass_q) begin
                gate_d = CMD;
            end else begin
                // both commands high turns both off, silently
                gate_d.high = CMD.high && !CMD.low && !gate_q.low
                           && (gate_q.high || gap_l_q >= dead_cyc_q);
                gate_d.low  = CMD.low && !CMD.high && !gate_q.high
                           && (gate_q.low || gap_h_q >= dead_cyc_q);
            end
        end
        gap_h_d   = gate_q.high ? '0 : sat_inc(gap_h_q);
        gap_l_d   = gate_q.low ? '0 : sat_inc(gap_l_q);
        blank_h_d = gate_q.high ? sat_inc(blank_h_q) : '0;
        blank_l_d = gate_q.low ? sat_inc(blank_l_q) : '0;
    end

    // strap capture, halt sequencing and error memory
    always_comb begin
        state_d  = state_q;
        dead_cyc_d = dead_cyc_q;
        bypass_d = bypass_q;
        timer_d  = timer_q;
        halt_d   = halt_q;
        fault_d  = fault_q;
        resumed  = 1'b0;
        low_d    = (CMD.high || CMD.low) ? '0
                 : ((low_q > LOW_W'(LOW_CYC)) ? low_q : low_q + LOW_W'(1));
        case (state_q)
            ST_INIT: begin
                dead_cyc_d = dead_time_cycles(STRAPS);
                bypass_d = !STRAPS.bypass_strap_n && STRAPS.dead_time_strap_a_n
                        && STRAPS.dead_time_strap_b_n
                        && STRAPS.dead_time_fine_strap_n;
                halt_d   = 1'b0;
                state_d  = ST_RUN;
            end
            ST_RUN: begin
                if (fail_evt) begin
                    state_d = ST_HALT;
                    halt_d  = 1'b1;
                    fault_d = 1'b1;
                    timer_d = '0;
                end
            end
            ST_HALT: begin
                if (timer_q < 32'(HALT_CYCLES)) begin
                    timer_d = timer_q + 32'd1;
                end
                if (resume_ok) begin
                    state_d = ST_RUN;
                    halt_d  = 1'b0;
                    fault_d = 1'b0;
                    resumed = 1'b1;
                end
            end
            default: begin
                state_d = ST_INIT;
                halt_d  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_q   <= ST_INIT;
            gate_q    <= '0;
            dead_cyc_q <= DEAD_DEFAULT_CYC;
            bypass_q  <= 1'b0;
            gap_h_q   <= '0;
            gap_l_q   <= '0;
            blank_h_q <= '0;
            blank_l_q <= '0;
            timer_q   <= '0;
            low_q     <= '0;
            halt_q    <= 1'b1;
            fault_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            gate_q    <= gate_d;
            dead_cyc_q <= dead_cyc_d;
            bypass_q  <= bypass_d;
            gap_h_q   <= gap_h_d;
            gap_l_q   <= gap_l_d;
            blank_h_q <= blank_h_d;
            blank_l_q <= blank_l_d;
            timer_q   <= timer_d;
            low_q     <= low_d;
            halt_q    <= halt_d;
            fault_q   <= fault_d;
        end
    end

    // register port: sticky status, mask, read mux
    always_comb begin
        logic [ST_W-1:0] ev;
        logic [ST_W-1:0] clr;
        ev = '0;
        ev[ST_HIGH_TRIP] = trip.high;
        ev[ST_LOW_TRIP]  = trip.low;
        ev[ST_EXT_FAIL]  = FAIL_IN && state_q == ST_RUN;
        ev[ST_RESUMED]   = resumed;
        clr = (REG_WR && REG_ADDR == OFS_STATUS) ? REG_WDATA[ST_W-1:0] : '0;
        status_d = (status_q & ~clr) | ev;                         // set wins over clear
        mask_d   = (REG_WR && REG_ADDR == OFS_MASK) ? REG_WDATA[ST_W-1:0] : mask_q;
        irq_d    = |(status_d & mask_d);
        rdata_d  = '0;
        if (REG_RD) begin
            case (REG_ADDR)
                OFS_STATUS: rdata_d[ST_W-1:0] = status_q;
                OFS_MASK:   rdata_d[ST_W-1:0] = mask_q;
                OFS_STATE: begin
                    rdata_d[SR_GATE_H] = gate_q.high;
                    rdata_d[SR_GATE_L] = gate_q.low;
                    rdata_d[SR_HALT]   = halt_q;
                    rdata_d[SR_FAULT]  = fault_q;
                    rdata_d[SR_BYPASS] = bypass_q;
                    rdata_d[SR_DEAD_LSB +: GAP_W] = dead_cyc_q;
                end
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            status_q <= '0;
            mask_q   <= MASK_RESET;
            irq_q    <= 1'b0;
            rdata_q  <= '0;
        end else begin
            status_q <= status_d;
            mask_q   <= mask_d;
            irq_q    <= irq_d;
            rdata_q  <= rdata_d;
        end
    end

    // outputs straight from flops
    assign GATE      = gate_q;
    assign HALT_OUT  = halt_q;
    assign FAULT_OUT = fault_q;
    assign IRQ       = irq_q;
    assign REG_RDATA = rdata_q;

    // checks
    no_overlap_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !bypass_q |-> !(gate_q.high && gate_q.low))
        else $error("both gates on with interlock active");
    dead_gap_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!bypass_q && $rose(gate_q.high)) |-> ($past(gap_l_q) >= dead_cyc_q))
        else $error("high side rose before dead time");
    dead_gap_low_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!bypass_q && $rose(gate_q.low)) |-> ($past(gap_h_q) >= dead_cyc_q))
        else $error("low side rose before dead time");
    overlap_quiet_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_q == ST_RUN && CMD.high && CMD.low && !trip.high && !trip.low
         && !FAIL_IN && !sw_fail) |=> (state_q == ST_RUN && !fault_q))
        else $error("overlap raised a fault");
    default_dead_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_q == ST_INIT && STRAPS.dead_time_strap_a_n && STRAPS.dead_time_strap_b_n
         && STRAPS.dead_time_fine_strap_n) |=> (dead_cyc_q == DEAD_DEFAULT_CYC))
        else $error("default dead time is not 4 us");
    bypass_pass_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (bypass_q && state_q == ST_RUN && !fail_evt) |=> (gate_q == $past(CMD)))
        else $error("bypass did not pass commands");
    blank_ignore_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(gate_q.high) |-> !trip.high [*8])
        else $error("trip acted on inside blanking");
    blank_restart_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(gate_q.low) |-> (blank_l_q == 10'd0))
        else $error("blanking did not restart");
    trip_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (trip.high && state_q == ST_RUN) |=> (!gate_q.high && fault_q && halt_q))
        else $error("trip did not turn off and latch");
    halt_block_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_q == ST_HALT) |=> (gate_q == '0 && halt_q == (state_q == ST_HALT)))
        else $error("commands passed during halt");
    resume_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_q == ST_HALT && !resume_ok) |=> (state_q == ST_HALT))
        else $error("left halt too early");
endmodule
`default_nettype wire

// [rtl/interlock_pkg.sv]
// constants, register map and carrier types of the half-bridge interlock
package interlock_pkg;
    // clock
    localparam int CLK_PERIOD_NS  = 8;
    localparam int CLK_HZ         = 125_000_000;
    // dead time steps
    localparam int DEAD_UNIT_NS   = 1000;
    localparam int DEAD_FINE_NS   = 300;
    localparam int DEAD_UNIT_CYC  = (DEAD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_FINE_CYC  = (DEAD_FINE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_W          = 10;
    localparam logic [GAP_W-1:0] DEAD_DEFAULT_CYC = GAP_W'(4 * DEAD_UNIT_CYC);
    // desaturation blanking interval
    localparam int BLANK_NS       = 2000;
    localparam int BLANK_CYC      = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // halt timer and command-low time before resume
    localparam int HALT_TIME_MS   = 3000;
    localparam int HALT_CYC       = HALT_TIME_MS * (CLK_HZ / 1000);
    localparam int LOW_TIME_NS    = 9000;
    localparam int LOW_CYC        = LOW_TIME_NS / CLK_PERIOD_NS;
    localparam int LOW_W          = 11;
    // register map, byte addresses
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_MASK   = 4'h4;
    localparam logic [3:0] OFS_CTRL   = 4'h8;
    localparam logic [3:0] OFS_STATE  = 4'hc;
    // status / mask bits
    localparam int ST_HIGH_TRIP   = 0;
    localparam int ST_LOW_TRIP    = 1;
    localparam int ST_EXT_FAIL    = 2;
    localparam int ST_RESUMED     = 3;
    localparam int ST_W           = 4;
    localparam logic [ST_W-1:0] MASK_RESET = 4'h0;
    // control bits
    localparam int CTRL_FAIL      = 0;
    // state register fields
    localparam int SR_GATE_H      = 0;
    localparam int SR_GATE_L      = 1;
    localparam int SR_HALT        = 2;
    localparam int SR_FAULT       = 3;
    localparam int SR_BYPASS      = 4;
    localparam int SR_DEAD_LSB    = 16;

    // one bit per side of the half bridge
    typedef struct packed {
        logic high;
        logic low;
    } side_t;

    // strap pins, low when grounded
    typedef struct packed {
        logic dead_time_strap_a_n;
        logic dead_time_strap_b_n;
        logic dead_time_fine_strap_n;
        logic bypass_strap_n;
    } straps_t;

    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_RUN  = 2'b01,
        ST_HALT = 2'b11
    } mode_t;
endpackage

// [sim/pwm_ctrl_model.sv]
// controller model driving the two switch commands
`timescale 1ns/1ps
`default_nettype none
module pwm_ctrl_model (
    input  wire logic            CLK,
    output interlock_pkg::side_t CMD
);
    import interlock_pkg::*;
    // both commands start low, switches off
    initial CMD = '0;
    // change the commands after an edge, hold them n cycles
    task automatic put(input side_t v, input int n);
        @(posedge CLK);
        CMD <= v;
        repeat (n - 1) @(posedge CLK);
    endtask
    // one waveform and its inverse, periods well over the dead time
    task automatic wave(input int halves, input int len);
        for (int i = 0; i < halves; i++) begin
            put(side_t'({i[0], !i[0]}), len);
        end
    endtask
endmodule
`default_nettype wire

// [sim/half_bridge_interlock_desat_tb.sv]
// self-checking bench of the half-bridge interlock
`timescale 1ns/1ps
`default_nettype none
module half_bridge_interlock_desat_tb;
    import interlock_pkg::*;
    logic        CLK;
    logic        SYS_RST;
    straps_t     straps;
    side_t       cmd;
    side_t       desat;
    side_t       gate;
    side_t       prev;
    logic        fail_in;
    logic        halt;
    logic        fault;
    logic        irq;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] d;
    logic        wr;
    logic        rd;
    logic        bypass_on;
    int          fail_count;
    int          checks_done;
    int          cnt_h;
    int          cnt_l;
    int          gap_h;
    int          gap_l;

    half_bridge_interlock_desat #(.HALT_CYCLES(200)) half_bridge_interlock_desat_i (
        .CLK(CLK), .SYS_RST(SYS_RST), .CMD(cmd), .STRAPS(straps), .DESAT(desat),
        .FAIL_IN(fail_in), .GATE(gate), .HALT_OUT(halt), .FAULT_OUT(fault), .IRQ(irq),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata)
    );
    pwm_ctrl_model pwm_ctrl_model_i (.CLK(CLK), .CMD(cmd));

    // clock, 8 ns period
    initial begin
        CLK = 1'b0;
        forever #(CLK_PERIOD_NS / 2) CLK = ~CLK;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic do_reset(input straps_t s);
        @(posedge CLK);
        SYS_RST <= 1'b1;
        straps  <= s;
        repeat (4) @(posedge CLK);
        SYS_RST <= 1'b0;
        cyc(2);
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge CLK);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge CLK);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge CLK);
        rd   <= 1'b1;
        addr <= a;
        @(posedge CLK);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    // overlap watch and gap measurement between the two gates
    always @(posedge CLK) begin
        #1;
        if (!SYS_RST && !bypass_on && gate.high && gate.low) chk(32'(gate), 32'h0);
        if (gate.low && !prev.low) gap_l = cnt_h;
        if (gate.high && !prev.high) gap_h = cnt_l;
        cnt_h = gate.high ? 0 : cnt_h + 1;
        cnt_l = gate.low ? 0 : cnt_l + 1;
        prev = gate;
    end

    // strap decoding, bypass, odd addresses
    task automatic t_straps();
        for (int i = 0; i < 8; i++) begin
            do_reset(straps_t'({i[2:0], 1'b1}));
            reg_rd(OFS_STATE, d);
            chk(32'(d[25:16]), 32'((2 * i[2] + i[1] + 1) * DEAD_UNIT_CYC
                + (i[0] ? 0 : DEAD_FINE_CYC)));
        end
        do_reset(4'he);
        bypass_on = 1'b1;
        reg_rd(OFS_STATE, d);
        chk(32'(d[SR_BYPASS]), 32'h1);
        pwm_ctrl_model_i.put(2'b11, 3);
        #1 chk(32'(gate), 32'h3);
        pwm_ctrl_model_i.put(2'b00, 3);
        bypass_on = 1'b0;
        do_reset(4'hf);
        reg_rd(4'h2, d);
        chk(d, 32'h0);
        reg_rd(OFS_CTRL, d);
        chk(d, 32'h0);
    endtask

    // dead time from the forwarded fall, never added to the controller gap
    task automatic t_dead();
        pwm_ctrl_model_i.put(2'b01, 800);
        pwm_ctrl_model_i.put(2'b10, 800);
        chk(32'(gap_h), 32'(DEAD_DEFAULT_CYC + 1));
        pwm_ctrl_model_i.put(2'b00, 700);
        pwm_ctrl_model_i.put(2'b01, 800);
        chk(32'(gap_l), 32'd700);
        pwm_ctrl_model_i.wave(6, 600);
        chk(32'(gap_h), 32'(DEAD_DEFAULT_CYC + 1));
        pwm_ctrl_model_i.put(2'b11, 20);
        #1 chk({gate, fault, irq}, 32'h0);
        reg_rd(OFS_STATUS, d);
        chk(d, 32'h0);
        pwm_ctrl_model_i.put(2'b00, 10);
    endtask

    // blanking, restart on turn-off, trip, interrupt and resume
    task automatic t_desat();
        reg_wr(OFS_MASK, 32'h3);
        desat <= 2'b11;
        pwm_ctrl_model_i.put(2'b10, 202);
        #1 chk({gate, fault}, 32'h4);
        pwm_ctrl_model_i.put(2'b00, 60);
        #1 chk(32'(fault), 32'h0);
        pwm_ctrl_model_i.put(2'b10, 202);
        #1 chk(32'(gate), 32'h2);
        cyc(60);
        chk({gate, fault, halt, irq}, 32'h7);
        reg_rd(OFS_STATUS, d);
        chk(d, 32'h1);
        desat <= 2'b00;
        reg_wr(OFS_STATUS, 32'h1);
        cyc(2);
        chk(32'(irq), 32'h0);
        pwm_ctrl_model_i.put(2'b00, 1000);
        #1 chk(32'(halt), 32'h1);
        cyc(300);
        chk({halt, fault, irq}, 32'h0);
        reg_rd(OFS_STATUS, d);
        chk(d, 32'h8);
        reg_wr(OFS_STATUS, 32'h8);
    endtask

    // persistent failure and injected failure
    task automatic t_fail();
        pwm_ctrl_model_i.put(2'b01, 600);
        fail_in <= 1'b1;
        cyc(3);
        chk({gate, halt, fault}, 32'h3);
        pwm_ctrl_model_i.put(2'b10, 50);
        #1 chk(32'(gate), 32'h0);
        pwm_ctrl_model_i.put(2'b00, 1500);
        #1 chk(32'(halt), 32'h1);
        fail_in <= 1'b0;
        cyc(5);
        chk(32'(halt), 32'h0);
        reg_rd(OFS_STATUS, d);
        chk(d, 32'hc);
        reg_wr(OFS_CTRL, 32'h1);
        cyc(3);
        chk({halt, fault}, 32'h3);
        cyc(1300);
        chk(32'(halt), 32'h0);
    endtask

    // sides judged apart: asserted high sense with the high side off stays quiet, then a low-side trip
    task automatic t_sides();
        reg_wr(OFS_STATUS, 32'hf);
        desat <= 2'b10;
        pwm_ctrl_model_i.put(2'b01, 300);
        #1 chk({gate, fault}, 32'h2);
        desat <= 2'b01;
        cyc(2);
        chk({gate, fault, halt, irq}, 32'h7);
        reg_rd(OFS_STATUS, d);
        chk(d, 32'h2);
        desat <= 2'b00;
        pwm_ctrl_model_i.put(2'b00, 10);
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #(CLK_PERIOD_NS * 40000);
        fail_count++;
        give_verdict();
    end

    // main sequence
    initial begin
        SYS_RST = 1'b1;
        straps = 4'hf;
        desat = '0;
        fail_in = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        bypass_on = 1'b0;
        prev = '0;
        repeat (4) @(posedge CLK);
        SYS_RST <= 1'b0;
        cyc(2);
        t_straps();
        t_dead();
        t_desat();
        t_fail();
        t_sides();
        give_verdict();
    end
endmodule
`default_nettype wire
